//--- rtl/tac_top.sv
// Purpose: Trigger arm control with AXI4-Lite register access.
// Assumes: Source lines and op_done are synchronous to aclk.
// Notes:   op_start asks the engine for one operation, op_done ends it.
`timescale 1ns/10ps
`include "tac_defs.svh"
module tac_top #(
    parameter int ADDR_W = 8,
    parameter int CNT_W = 16,
    parameter int DLY_W = 32
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_trig,
    input wire logic [7:0] backplane_trig,
    input wire logic timer_evt,
    input wire logic [6:0] inst_evt,
    input wire logic hs_request,
    input wire logic [25:0] hw_fitted,
    input wire logic op_done,
    output logic op_start,
    output logic hs_strobe,
    output logic armed
);
    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    typedef struct packed {
        tac_pkg::tac_state_t state;
        logic [4:0] sel_src;
        logic [4:0] arm_src;
        logic mode_all;
        logic pol_req_fall;
        logic pol_strb_fall;
        logic [DLY_W-1:0] delay;
        logic [CNT_W-1:0] event_count_setting;
        logic [CNT_W-1:0] opcount;
        logic [CNT_W-1:0] opsdone;
        logic init_p;
        logic abort_p;
        logic force_p;
        logic bus_p;
        logic [4:0] cmd_p;
        logic aw_have;
        logic [ADDR_W-1:0] awaddr;
        logic w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic op_start;
        logic strobe;
        logic armed;
    } tac_top_st_t;

    localparam tac_top_st_t RST_ST = '{
        state: tac_pkg::ST_IDLE,
        sel_src: `TAC_SRC_RST,
        arm_src: `TAC_SRC_RST,
        mode_all: `TAC_MODE_RST,
        pol_req_fall: `TAC_POL_RST,
        pol_strb_fall: `TAC_POL_RST,
        opcount: CNT_W'(`TAC_OPCOUNT_RST),
        awready: 1'b1,
        wready: 1'b1,
        arready: 1'b1,
        strobe: `TAC_POL_RST,
        default: '0
    };

    tac_top_st_t q;
    tac_top_st_t d;

    logic [16:0] edge_p;
    logic req_p;
    logic [31:0] ev;
    logic [25:0] present;
    logic sel_ev;
    logic delayable;
    logic qual_fire;
    logic qual_clr;
    logic qual_ev;
    logic last_op;

    // -----------------------------------------------------------------
    // Source events
    // -----------------------------------------------------------------
    tac_edge #(.W(17)) u_lines (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .sig({inst_evt, timer_evt, backplane_trig, ext_trig}),
        .fall(17'h0),
        .pulse(edge_p)
    );

    // Request edge follows its own polarity setting; see RULE_03
    tac_edge #(.W(1)) u_req (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .sig(hs_request),
        .fall(q.pol_req_fall),
        .pulse(req_p)
    );

    // Bit index equals source code; see RULE_09
    assign ev = {6'h0, req_p, edge_p[16:9], q.cmd_p, edge_p[8:0],
                 q.bus_p, 1'b1, 1'b0};
    // Unfitted option hardware is absent from every catalogue; see RULE_11
    assign present = hw_fitted | `TAC_ALWAYS_MASK;
    assign sel_ev = ev[q.arm_src];
    // See RULE_10
    assign delayable = 1'(`TAC_DLY_MASK >> q.arm_src);
    assign qual_clr = q.state != tac_pkg::ST_WAIT;
    assign qual_ev = !qual_clr && delayable && sel_ev;
    assign last_op = (q.opsdone + CNT_W'(1)) >= q.opcount;

    tac_qual #(.CNT_W(CNT_W), .DLY_W(DLY_W)) u_qual (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .clr(qual_clr),
        .ev(qual_ev),
        .event_count_setting(q.event_count_setting),
        .delay(q.delay),
        .fire(qual_fire)
    );

    // -----------------------------------------------------------------
    // Register access helpers
    // -----------------------------------------------------------------
    // Returns {mapped, data}
    function automatic logic [32:0] rd_reg(logic [ADDR_W-1:0] a);
        logic [32:0] r;
        r = {1'b1, 32'h0};
        case (a)
            `TAC_OFF_CTRL: r[31:0] = 32'h0;
            `TAC_OFF_SOURCE: r[4:0] = q.sel_src; // see RULE_08
            `TAC_OFF_MODE: r[0] = q.mode_all; // see RULE_12
            `TAC_OFF_POL: r[1:0] = {q.pol_strb_fall, q.pol_req_fall};
            `TAC_OFF_DELAY: r[31:0] = 32'(q.delay);
            `TAC_OFF_EVENT_COUNT_SETTING: r[31:0] = 32'(q.event_count_setting);
            `TAC_OFF_OPCOUNT: r[31:0] = 32'(q.opcount);
            `TAC_OFF_STATUS: begin
                r[`TAC_ST_INIT] = q.state != tac_pkg::ST_IDLE;
                r[`TAC_ST_BUSY] = q.state == tac_pkg::ST_OP;
                r[31:16] = 16'(q.opsdone);
            end
            `TAC_OFF_CAT_ALL: r[25:0] = present;
            `TAC_OFF_CAT_DLY: r[25:0] = present & `TAC_DLY_MASK;
            `TAC_OFF_CAT_FIX: r[25:0] = present & `TAC_FIX_MASK;
            `TAC_OFF_SWCMD: r[31:0] = 32'h0;
            default: r = 33'h0;
        endcase
        return r;
    endfunction

    function automatic logic [31:0] merge(logic [31:0] old,
                                          logic [31:0] nw,
                                          logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return m;
    endfunction

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    always_comb begin
        logic [32:0] rv;
        logic [31:0] wv;
        logic strb_p;
        rv = '0;
        wv = '0;
        strb_p = 1'b0;
        d = q;
        d.op_start = 1'b0;
        d.init_p = 1'b0;
        d.abort_p = 1'b0;
        d.force_p = 1'b0;
        d.bus_p = 1'b0;
        d.cmd_p = 5'h0;

        // Write address and data, accepted in either order
        if (q.awready && s_axi_awvalid) begin
            d.aw_have = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (q.wready && s_axi_wvalid) begin
            d.w_have = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.aw_have && q.w_have && !q.bvalid) begin
            rv = rd_reg(q.awaddr);
            wv = merge(rv[31:0], q.wdata, q.wstrb);
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = rv[32] ? `TAC_RESP_OKAY : `TAC_RESP_SLVERR;
            case (q.awaddr)
                `TAC_OFF_CTRL: begin
                    d.init_p = wv[`TAC_CTRL_INIT];
                    d.abort_p = wv[`TAC_CTRL_ABORT];
                    d.force_p = wv[`TAC_CTRL_FORCE];
                    d.bus_p = wv[`TAC_CTRL_BUS];
                end
                `TAC_OFF_SOURCE: begin
                    // Absent or unknown sources are refused; see RULE_11
                    if (wv[4:0] < `TAC_NSRC && present[wv[4:0]]) begin
                        d.sel_src = wv[4:0];
                    end else begin
                        d.bresp = `TAC_RESP_SLVERR;
                    end
                end
                `TAC_OFF_MODE: d.mode_all = wv[0];
                `TAC_OFF_POL: begin
                    d.pol_req_fall = wv[`TAC_POL_REQ]; // see RULE_03
                    d.pol_strb_fall = wv[`TAC_POL_STRB];
                end
                `TAC_OFF_DELAY: begin
                    d.delay = DLY_W'(wv);
                    d.event_count_setting = '0; // see RULE_15
                end
                `TAC_OFF_EVENT_COUNT_SETTING: begin
                    d.event_count_setting = CNT_W'(wv); // see RULE_13
                    d.delay = '0; // see RULE_15
                end
                `TAC_OFF_OPCOUNT: d.opcount = CNT_W'(wv);
                `TAC_OFF_SWCMD: d.cmd_p = wv[4:0];
                default: d.bresp = `TAC_RESP_SLVERR;
            endcase
        end
        d.awready = !d.aw_have;
        d.wready = !d.w_have;

        // Read channel
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
            d.arready = 1'b1;
        end
        if (q.arready && s_axi_arvalid) begin
            rv = rd_reg(s_axi_araddr);
            d.rdata = rv[31:0];
            d.rresp = rv[32] ? `TAC_RESP_OKAY : `TAC_RESP_SLVERR;
            d.rvalid = 1'b1;
            d.arready = 1'b0;
        end

        // Trigger sequencing
        case (q.state)
            tac_pkg::ST_IDLE: begin
                if (q.init_p) begin
                    d.state = tac_pkg::ST_WAIT;
                    d.arm_src = q.sel_src; // see RULE_08
                    d.opsdone = '0;
                end
            end
            tac_pkg::ST_WAIT: begin
                if (q.abort_p) begin
                    d.state = tac_pkg::ST_IDLE;
                end else if (q.force_p || (!delayable && sel_ev)
                             || qual_fire) begin
                    // Forced once, fixed direct, else qualified;
                    // see RULE_04, see RULE_16
                    d.state = tac_pkg::ST_OP;
                    d.op_start = 1'b1;
                end
            end
            tac_pkg::ST_OP: begin
                if (q.abort_p) begin
                    d.state = tac_pkg::ST_IDLE;
                end else if (op_done) begin
                    d.opsdone = q.opsdone + CNT_W'(1);
                    strb_p = 1'b1;
                    if (last_op) begin
                        d.state = tac_pkg::ST_IDLE; // see RULE_07
                    end else if (q.mode_all) begin
                        d.op_start = 1'b1; // see RULE_05
                    end else begin
                        d.state = tac_pkg::ST_WAIT; // see RULE_06
                    end
                end
            end
            default: d.state = tac_pkg::ST_IDLE;
        endcase
        // Strobe idles at the inactive level; see RULE_01, see RULE_02
        d.strobe = q.pol_strb_fall ^ strb_p;
        d.armed = d.state == tac_pkg::ST_WAIT;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= RST_ST;
        end else if (ce) begin
            q <= d;
        end
    end

    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign op_start = q.op_start;
    assign hs_strobe = q.strobe;
    assign armed = q.armed;

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    force_trig_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_04
        ce && q.state == tac_pkg::ST_WAIT && q.force_p && !q.abort_p
        |=> q.state == tac_pkg::ST_OP && q.op_start)
        else $error("forced trigger did not start an operation");

    all_mode_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_05
        ce && q.state == tac_pkg::ST_OP && op_done && !q.abort_p
        && q.mode_all && !last_op
        |=> q.state == tac_pkg::ST_OP && q.op_start)
        else $error("all mode did not continue with next operation");

    once_mode_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_06
        ce && q.state == tac_pkg::ST_OP && op_done && !q.abort_p
        && !q.mode_all && !last_op
        |=> q.state == tac_pkg::ST_WAIT && q.armed)
        else $error("one-per-trigger mode did not return to waiting");

    count_done_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_07
        ce && q.state == tac_pkg::ST_OP && op_done && !q.abort_p && last_op
        |=> q.state == tac_pkg::ST_IDLE && q.opsdone == $past(q.opsdone) + 1)
        else $error("sequence did not end after the last operation");

    one_qual_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_15
        q.event_count_setting != '0 |-> q.delay == '0)
        else $error("delay and event count both active");

    idle_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_17
        ce && q.state != tac_pkg::ST_WAIT |=> !qual_fire)
        else $error("qualifier fired outside the waiting state");

    fixed_src_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_16
        ce && q.state == tac_pkg::ST_WAIT && !q.abort_p && !delayable && sel_ev
        |=> q.state == tac_pkg::ST_OP)
        else $error("fixed source did not trigger directly");

    strobe_pol_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_02
        ce && q.state == tac_pkg::ST_OP && op_done && !q.abort_p
        |=> hs_strobe == !$past(q.pol_strb_fall) ##1 hs_strobe == q.pol_strb_fall
            || !$past(ce))
        else $error("strobe not driven on its active edge");
endmodule

//--- include/tac_defs.svh
// Purpose: Constants of the trigger arm control block.
// Assumes: Byte addresses on the AXI4-Lite register bus.
// Notes:   Offsets, field positions, reset values and source masks.
//
// Contract
// RULE_01: With rising_edge_active the rising edge of a handshake line is active.
// RULE_02: With falling_edge_active the falling edge is active, sampled and driven.
// RULE_03: Request and strobe lines have separate, readable polarity settings.
// RULE_04: A forced trigger enters the triggered state once without the source.
// RULE_05: In all-operations mode one trigger runs every configured operation.
// RULE_06: In one-per-trigger mode a trigger runs one operation, then waits again.
// RULE_07: One-per-trigger repeats until the configured count of operations is done.
// RULE_08: The selected source is latched at initiate and reads back.
// RULE_09: The selector offers the full catalogue of twenty-six sources.
// RULE_10: Only the delayable subset honours delay and count qualification.
// RULE_11: Unfitted sources are unavailable and left out of the catalogue.
// RULE_12: Mode, delay and event count all read back.
// RULE_13: Event count zero is pass-through, else 1 to 65535 triggers.
// RULE_14: With event count N the Nth qualifying event triggers.
// RULE_15: Writing delay clears count and writing count clears delay.
// RULE_16: Fixed sources ignore delay and count and trigger directly.
// RULE_17: Events while not initiated are ignored and are not counted.
`ifndef TAC_DEFS_SVH
`define TAC_DEFS_SVH

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define TAC_OFF_CTRL     8'h00
`define TAC_OFF_SOURCE   8'h04
`define TAC_OFF_MODE     8'h08
`define TAC_OFF_POL      8'h0c
`define TAC_OFF_DELAY    8'h10
`define TAC_OFF_EVENT_COUNT_SETTING   8'h14
`define TAC_OFF_OPCOUNT  8'h18
`define TAC_OFF_STATUS   8'h1c
`define TAC_OFF_CAT_ALL  8'h20
`define TAC_OFF_CAT_DLY  8'h24
`define TAC_OFF_CAT_FIX  8'h28
`define TAC_OFF_SWCMD    8'h2c

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define TAC_CTRL_INIT    0
`define TAC_CTRL_ABORT   1
`define TAC_CTRL_FORCE   2
`define TAC_CTRL_BUS     3
`define TAC_POL_REQ      0
`define TAC_POL_STRB     1
`define TAC_ST_INIT      0
`define TAC_ST_BUSY      1

// -----------------------------------------------------------------
// Reset values and source masks
// -----------------------------------------------------------------
`define TAC_NSRC         5'h1a
`define TAC_SRC_RST      5'h01
`define TAC_MODE_RST     1'h1
`define TAC_POL_RST      1'h1
`define TAC_OPCOUNT_RST  16'h0001
`define TAC_DLY_MASK     26'h1fdfffc
`define TAC_FIX_MASK     26'h2020003
`define TAC_ALWAYS_MASK  26'h001f007
`define TAC_RESP_OKAY    2'h0
`define TAC_RESP_SLVERR  2'h2

`endif

//--- include/tac_pkg.sv
// Purpose: Shared types of the trigger arm control block.
// Assumes: Source codes double as bit indices of the event vector.
// Notes:   Defines live in tac_defs.svh.
package tac_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_OP   = 3'b100
    } tac_state_t;

    typedef enum logic [4:0] {
        SRC_HOLD = 5'h00, SRC_IMM = 5'h01, SRC_BUS = 5'h02,
        SRC_EXT = 5'h03, SRC_BP0 = 5'h04, SRC_CMD0 = 5'h0c,
        SRC_TIMER = 5'h11, SRC_RELAY = 5'h12, SRC_METER = 5'h13,
        SRC_CTR = 5'h14, SRC_CTR_ARM = 5'h15, SRC_WAVE = 5'h16,
        SRC_DIG_IN = 5'h17, SRC_DIG_OUT = 5'h18, SRC_HANDSHAKE = 5'h19
    } tac_src_t;

endpackage

//--- rtl/tac_edge.sv
// Purpose: Active-edge detector for a group of trigger lines.
// Assumes: Lines are synchronous to aclk.
// Notes:   Per-bit polarity; pulse is one cycle, registered.
`timescale 1ns/10ps
module tac_edge #(
    parameter int W = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [W-1:0] sig,
    input wire logic [W-1:0] fall,
    output logic [W-1:0] pulse
);
    typedef struct packed {
        logic [W-1:0] prev;
        logic [W-1:0] pulse;
    } tac_edge_st_t;

    tac_edge_st_t q;
    tac_edge_st_t d;

    always_comb begin
        d = q;
        d.prev = sig;
        // Rising or falling edge chosen line by line; see RULE_01, see RULE_02
        d.pulse = (fall & q.prev & ~sig) | (~fall & sig & ~q.prev);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign pulse = q.pulse;
endmodule

//--- rtl/tac_qual.sv
// Purpose: Event-count or time-delay qualifier of trigger events.
// Assumes: At most one of event_count_setting and delay is non-zero.
// Notes:   fire is a registered pulse; delay counts aclk cycles.
`timescale 1ns/10ps
module tac_qual #(
    parameter int CNT_W = 16,
    parameter int DLY_W = 32
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic clr,
    input wire logic ev,
    input wire logic [CNT_W-1:0] event_count_setting,
    input wire logic [DLY_W-1:0] delay,
    output logic fire
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [DLY_W-1:0] dly;
        logic run;
        logic fire;
    } tac_qual_st_t;

    tac_qual_st_t q;
    tac_qual_st_t d;

    always_comb begin
        d = q;
        d.fire = 1'b0;
        if (clr) begin
            // Nothing is counted outside the waiting state; see RULE_17
            d.cnt = '0;
            d.run = 1'b0;
        end else if (q.run) begin
            if (q.dly == DLY_W'(1)) begin
                d.fire = 1'b1;
                d.run = 1'b0;
            end else begin
                d.dly = q.dly - DLY_W'(1);
            end
        end else if (ev) begin
            if (event_count_setting != '0) begin
                // Nth event triggers; see RULE_14
                if (q.cnt + CNT_W'(1) == event_count_setting) begin
                    d.fire = 1'b1;
                    d.cnt = '0;
                end else begin
                    d.cnt = q.cnt + CNT_W'(1);
                end
            end else if (delay != '0) begin
                d.run = 1'b1;
                d.dly = delay;
            end else begin
                // Zero qualifier passes the first event; see RULE_13
                d.fire = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign fire = q.fire;
endmodule

//--- sim/tac_peer.sv
// Purpose: Far-side model: operation engine and handshake peer.
// Assumes: Engine raises op_done three cycles after op_start.
// Notes:   go holds the request line at its active level.
`timescale 1ns/10ps
module tac_peer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic op_start,
    input wire logic go,
    input wire logic fall,
    output logic op_done = 1'b0,
    output logic hs_request = 1'b0
);
    // ------------------------------------------------
    // Engine and request line
    // ------------------------------------------------
    logic [1:0] pend_q = 2'h0;
    always @(posedge aclk) begin
        pend_q <= aresetn ? {pend_q[0], op_start} : 2'h0;
        op_done <= aresetn & pend_q[1];
        // Idle at the inactive level, so go makes one active edge
        hs_request <= go ^ fall;
    end
endmodule

//--- sim/trigger_arm_control_bench.sv
// Purpose: Self-checking bench of the trigger arm control block.
// Assumes: Partner engine answers each start.
// Notes:   Operation count is modelled as an integer.
`timescale 1ns/10ps
module trigger_arm_control_bench;
    // ------------------------------------------------
    // Signals and design
    // ------------------------------------------------
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0;
    logic arv = 0, rready = 0, ext = 0, tmr = 0, go = 0, rfall = 0;
    logic spol = 1;
    logic [7:0] bp = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd_d, e;
    logic [25:0] fit = '1;
    logic [1:0] bresp, rresp, rs;
    logic awr, wrd, bv, arr, rv, op_start, op_done, hs_strobe, armed;
    logic hs_req;
    int n_fail = 0, n_checks = 0, ops = 0, strb = 0, cyc = 0, x_ops = 0;
    int seed = 32'h347cd7c3;
    always #4 aclk = ~aclk;
    tac_top DUT (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready),
        .ext_trig(ext), .backplane_trig(bp), .timer_evt(tmr),
        .inst_evt(7'h0), .hs_request(hs_req), .hw_fitted(fit),
        .op_done(op_done), .op_start(op_start), .hs_strobe(hs_strobe),
        .armed(armed));
    tac_peer peer (.aclk(aclk), .aresetn(aresetn), .op_start(op_start),
        .go(go), .fall(rfall), .op_done(op_done), .hs_request(hs_req));
    always @(posedge aclk) begin
        cyc++;
        ops += op_start;
        if (hs_strobe !== spol)
            strb++;
        if (cyc == 20000) begin
            n_fail++;
            close_out;
        end
    end
    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    task close_out;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] x, input logic [31:0] g, input string n);
        n_checks++;
        if (g !== x) begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", n, x, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bit gb;
        gb = 0;
        awaddr <= a;
        wdata <= d;
        awv <= 1;
        wv <= 1;
        bready <= 1;
        while (!gb) begin
            @(posedge aclk);
            if (awv && awr)
                awv <= 0;
            if (wv && wrd)
                wv <= 0;
            if (bv) begin
                gb = 1;
                rs = bresp;
                bready <= 0;
            end
        end
        @(posedge aclk);
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] x);
        bit gr;
        gr = 0;
        araddr <= a;
        arv <= 1;
        rready <= 1;
        while (!gr) begin
            @(posedge aclk);
            if (arv && arr)
                arv <= 0;
            if (rv) begin
                gr = 1;
                rd_d = rdata;
                rs = rresp;
                rready <= 0;
            end
        end
        @(posedge aclk);
        chk(x, rd_d, $sformatf("reg %h", a));
    endtask
    task pls(input bit t);
        if (t)
            tmr <= 1;
        else
            ext <= 1;
        repeat (3) @(posedge aclk);
        ext <= 0;
        tmr <= 0;
        repeat (3) @(posedge aclk);
    endtask
    task wops;
        repeat (60) begin
            if (ops == x_ops)
                break;
            @(posedge aclk);
        end
        repeat (6) @(posedge aclk);
        chk(x_ops, ops, "ops");
    endtask
    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rchk(8'h04, 1);
        rchk(8'h08, 1);
        rchk(8'h0c, 3);
        e = $random(seed) & 32'hffff;
        wr(8'h14, e);
        rchk(8'h14, e);
        wr(8'h10, 5);
        rchk(8'h14, 0);
        rchk(8'h10, 5);
        wr(8'h14, e);
        rchk(8'h10, 0);
        rchk(8'h30, 0);
        chk(2, rs, "rresp");
        rchk(8'h20, 32'h03ffffff);
        rchk(8'h24, 32'h01fdfffc);
        rchk(8'h28, 32'h02020003);
        fit[3] <= 0;
        rchk(8'h20, 32'h03fffff7);
        wr(8'h04, 3);
        chk(2, rs, "bresp");
        rchk(8'h04, 1);
        fit[3] <= 1;
        wr(8'h0c, 0);
        repeat (3) @(posedge aclk);
        spol = 0;
        strb = 0;
        wr(8'h18, 3);
        wr(8'h00, 1);
        x_ops += 3;
        wops;
        chk(3, strb, "strobes");
        rchk(8'h1c, 32'h00030000);
        wr(8'h08, 0);
        wr(8'h04, 3);
        wr(8'h18, 2);
        wr(8'h14, 2);
        pls(0);
        pls(0);
        wr(8'h00, 1);
        pls(0);
        chk(x_ops, ops, "ops");
        pls(0);
        x_ops++;
        wops;
        chk(1, armed, "armed");
        pls(0);
        pls(0);
        x_ops++;
        wops;
        rchk(8'h1c, 32'h00020000);
        wr(8'h04, 25);
        wr(8'h08, 1);
        wr(8'h18, 1);
        for (int p = 0; p < 2; p++) begin
            wr(8'h0c, p);
            rfall <= p[0];
            wr(8'h00, 1);
            go <= 1;
            repeat (3) @(posedge aclk);
            go <= 0;
            x_ops++;
            wops;
        end
        rchk(8'h0c, 1);
        wr(8'h04, 17);
        wr(8'h00, 1);
        pls(1);
        x_ops++;
        wops;
        wr(8'h04, 0);
        wr(8'h08, 0);
        wr(8'h18, 2);
        wr(8'h00, 1);
        wr(8'h00, 4);
        x_ops++;
        wops;
        repeat (20) @(posedge aclk);
        chk(x_ops, ops, "ops");
        rchk(8'h1c, 32'h00010001);
        wr(8'h00, 2);
        wr(8'h04, 4 + (e & 7));
        wr(8'h10, 8);
        wr(8'h00, 1);
        bp <= 8'h1 << (e & 7);
        repeat (3) @(posedge aclk);
        bp <= 0;
        repeat (3) @(posedge aclk);
        chk(x_ops, ops, "ops");
        x_ops++;
        wops;
        close_out;
    end
endmodule
